// [rtl/ossw_wavegen.sv]
// Per-channel code sequencer with safe state, margin slewing and waveforms behind APB
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - All channels Hi-Z after reset
// - Power up channel straight to stored code
// - Safe state from pin or trigger bit
// - Select 00 Hi-Z; 01 stored code then Hi-Z
// - Select 10/11 slew to margin then Hi-Z
// - Host writes ignored while safe state runs
// - Safe-state flag set on trigger
// - Status read clears flag after completion
// - No-slew period: data write applies at once
// - Margin command steps code toward margin value
// - Step size from 3-bit field table
// - Step period from 4-bit field table
// - Full slew takes ceiling(span/step)+1 periods
// - Each channel runs waveforms independently
// - 000 triangle between margin-low and margin-high
// - Triangle uses equal step counts each way
// - 001 rising sawtooth, 010 falling sawtooth
// - 100 sine, 24 points, one per period
module ossw_wavegen #(
    parameter int                 NCH      = ossw_pkg::NCH_DEF,
    parameter int                 CW       = ossw_pkg::CW_DEF,
    parameter logic [CW-1:0]      NVM_CODE = '0,
    parameter ossw_pkg::ossw_cyc_t STEP_CYC = ossw_pkg::STEP_CYC_DEF
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // APB slave
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Safe-state input
    input  wire logic               multifunction_pin,
    // Converter side
    output logic      [NCH*CW-1:0]  dacCode,
    output logic      [NCH-1:0]     outHiZ
);
    import ossw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [2:0]        ctrl, next_ctrl;             // Safe select and pin enable
    logic [CW-1:0]     dataReg  [NCH];              // Data codes
    logic [CW-1:0]     mHigh    [NCH];              // Margin-high codes
    logic [CW-1:0]     mLow     [NCH];              // Margin-low codes
    logic [FN_W-1:0]   func     [NCH];              // channel_function_reg
    logic [CW-1:0]     code     [NCH];              // Live converter code
    logic [CW-1:0]     target   [NCH];              // Slew target
    logic [31:0]       tmr      [NCH];              // Step period countdown
    logic              dirUp    [NCH];              // Triangle direction
    logic [4:0]        sineIdx  [NCH];              // Sine point
    ossw_ch_t          mode     [NCH];
    logic [NCH-1:0]    hiZ;
    logic [CW-1:0]     next_dataReg [NCH];
    logic [CW-1:0]     next_mHigh   [NCH];
    logic [CW-1:0]     next_mLow    [NCH];
    logic [FN_W-1:0]   next_func    [NCH];
    logic [CW-1:0]     next_code    [NCH];
    logic [CW-1:0]     next_target  [NCH];
    logic [31:0]       next_tmr     [NCH];
    logic              next_dirUp   [NCH];
    logic [4:0]        next_sineIdx [NCH];
    ossw_ch_t          next_mode    [NCH];
    logic [NCH-1:0]    next_hiZ;
    ossw_ss_t          ssState, next_ssState;       // Safe-state sequencer
    logic              ssFlag, next_ssFlag;         // Safe-state flag
    logic              pinPrev, next_pinPrev;       // Pin level last cycle
    logic [31:0]       next_prdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic              setup, acc, wrAcc, rdAcc, ssBusy, ssTrig, chHit, mapped;
    logic [7:0]        chOff;
    int                chSel;

    // Cycles per step minus one; zero when the period field means no slew
    function automatic logic [31:0] reloadOf(input logic [3:0] per);
        return (per == 4'h0) ? 32'h0 : 32'(STEP_CYC[per - 4'h1] - 1);
    endfunction : reloadOf

    // One step toward a target, clipped so it never overshoots
    function automatic logic [CW-1:0] stepTo(input logic [CW-1:0] cur,
                                             input logic [CW-1:0] tgt,
                                             input logic [2:0]    sel);
        logic [CW+6:0] s;
        s = {7'h0, cur};
        if (cur < tgt) begin
            s = s + {{(CW+1){1'b0}}, STEP_LSB[sel]};
            return (s >= {7'h0, tgt}) ? tgt : s[CW-1:0];
        end
        if ({7'h0, cur} <= {7'h0, tgt} + {{(CW+1){1'b0}}, STEP_LSB[sel]}) return tgt;
        return cur - CW'(STEP_LSB[sel]);
    endfunction : stepTo

    // Phase and address decode; channel blocks follow the common registers
    always_comb begin
        setup   = psel & ~penable;
        acc     = psel & penable;
        ssBusy  = (ssState != SS_IDLE);
        wrAcc   = acc & pwrite & ~ssBusy;
        rdAcc   = acc & ~pwrite;
        chOff   = paddr - CH_BASE;
        chSel   = int'(chOff[7:4]);
        chHit   = (paddr >= CH_BASE) && (chSel < NCH) && (paddr[1:0] == 2'b00);
        mapped  = chHit || paddr == REG_CTRL || paddr == REG_TRIG || paddr == REG_STATUS;
        pready  = 1'b1;                                                // Zero wait states
        pslverr = acc & ~mapped;                                       // Unmapped answers error
        // Rising pin edge only counts when the pin is assigned to the safe input
        ssTrig  = ~ssBusy & ((wrAcc && paddr == REG_TRIG && pwdata[TRIG_SAFE]) |
                  (ctrl[CTRL_PIN_EN] & multifunction_pin & ~pinPrev));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup phase so prdata comes straight from a flop
    always_comb begin
        next_prdata = 32'h0;
        if (setup) begin
            if (paddr == REG_CTRL) next_prdata[2:0] = ctrl;
            else if (paddr == REG_STATUS) begin
                next_prdata[ST_FLAG] = ssFlag;
                next_prdata[ST_BUSY] = ssBusy;
                for (int c = 0; c < NCH; c++) begin
                    next_prdata[ST_SLEW + c] = (mode[c] == CH_SLEW);
                    next_prdata[ST_HIZ + c]  = hiZ[c];
                end
            end else if (chHit) begin
                case (chOff[3:0])
                    CH_DATA:  next_prdata[CW-1:0]   = dataReg[chSel];
                    CH_MHIGH: next_prdata[CW-1:0]   = mHigh[chSel];
                    CH_MLOW:  next_prdata[CW-1:0]   = mLow[chSel];
                    CH_FUNC:  next_prdata[FN_W-1:0] = func[chSel];
                    default:  next_prdata = 32'h0;                      // Holes read zero
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Safe-state sequencer and flag
    always_comb begin
        next_ssState = ssState;
        next_ssFlag  = ssFlag;
        next_pinPrev = multifunction_pin;
        next_ctrl    = ctrl;
        if (wrAcc && paddr == REG_CTRL) next_ctrl = pwdata[2:0];
        // Clear on status read only after completion; a new trigger wins over it
        if (rdAcc && paddr == REG_STATUS && !ssBusy) next_ssFlag = 1'b0;
        case (ssState)
            SS_IDLE: begin
                if (ssTrig) begin
                    next_ssFlag = 1'b1;
                    case (ctrl[1:0])
                        SS_HIZ_ONLY: next_ssState = SS_HIZ;
                        SS_STORED:   next_ssState = SS_JUMP;
                        default:     next_ssState = SS_SLEWING;
                    endcase
                end
            end
            SS_JUMP: next_ssState = SS_HIZ;
            SS_SLEWING: begin
                // Wait until every channel has landed on its margin code
                next_ssState = SS_HIZ;
                for (int c = 0; c < NCH; c++) begin
                    if (mode[c] == CH_SLEW) next_ssState = SS_SLEWING;
                end
            end
            SS_HIZ:  next_ssState = SS_IDLE;
            default: next_ssState = SS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel registers, slewing and waveform generation
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            next_dataReg[c] = dataReg[c];
            next_mHigh[c]   = mHigh[c];
            next_mLow[c]    = mLow[c];
            next_func[c]    = func[c];
            next_code[c]    = code[c];
            next_target[c]  = target[c];
            next_tmr[c]     = (tmr[c] == 32'h0) ? 32'h0 : tmr[c] - 32'h1;
            next_dirUp[c]   = dirUp[c];
            next_sineIdx[c] = sineIdx[c];
            next_mode[c]    = mode[c];
            next_hiZ[c]     = hiZ[c];

            // Host writes; the host keeps off data and step fields while slewing
            if (wrAcc && chHit && chSel == c) begin
                case (chOff[3:0])
                    CH_DATA: begin
                        next_dataReg[c] = pwdata[CW-1:0];
                        next_code[c]    = pwdata[CW-1:0];
                    end
                    CH_MHIGH: next_mHigh[c] = pwdata[CW-1:0];
                    CH_MLOW:  next_mLow[c]  = pwdata[CW-1:0];
                    CH_FUNC: begin
                        next_func[c] = pwdata[FN_W-1:0];
                        if (pwdata[FN_RUN]) begin
                            // Waveform starts at the minimum, rising
                            next_mode[c]    = CH_WAVE;
                            next_code[c]    = mLow[c];
                            next_dirUp[c]   = 1'b1;
                            next_sineIdx[c] = 5'h0;
                            next_tmr[c]     = reloadOf(pwdata[FN_PER_LSB +: 4]);
                        end else if (mode[c] == CH_WAVE) next_mode[c] = CH_STATIC;
                    end
                    default: next_mode[c] = mode[c];
                endcase
            end
            if (wrAcc && paddr == REG_TRIG) begin
                if (pwdata[TRIG_PWRUP + c]) begin
                    next_code[c] = NVM_CODE;
                    next_hiZ[c]  = 1'b0;
                end
                if (pwdata[TRIG_PWRDN + c]) next_hiZ[c] = 1'b1;
                if (pwdata[TRIG_MHIGH + c] || pwdata[TRIG_MLOW + c]) begin
                    next_mode[c]   = CH_SLEW;
                    next_target[c] = pwdata[TRIG_MHIGH + c] ? mHigh[c] : mLow[c];
                    next_tmr[c]    = reloadOf(func[c][FN_PER_LSB +: 4]);
                end
            end

            // Safe-state effects on every channel
            if (ssState == SS_IDLE && ssTrig && ctrl[1]) begin
                next_mode[c]   = CH_SLEW;
                next_target[c] = (ctrl[1:0] == SS_TO_LOW) ? mLow[c] : mHigh[c];
                next_tmr[c]    = reloadOf(func[c][FN_PER_LSB +: 4]);
            end
            if (ssState == SS_JUMP) begin
                next_mode[c] = CH_STATIC;
                next_code[c] = NVM_CODE;
            end
            if (ssState == SS_HIZ) begin
                next_hiZ[c]          = 1'b1;
                next_mode[c]         = CH_STATIC;
                next_func[c][FN_RUN] = 1'b0;                           // Waveform does not resume
            end

            // Timed updates; one update per period expiry
            case (mode[c])
                CH_SLEW: begin
                    if (func[c][FN_PER_LSB +: 4] == 4'h0) begin
                        next_code[c] = target[c];                      // No slew: jump
                        next_mode[c] = CH_STATIC;
                    end else if (tmr[c] == 32'h0) begin
                        // Step lands on target after ceiling(span/step) updates
                        next_code[c] = stepTo(code[c], target[c], func[c][FN_STEP_LSB +: 3]);
                        next_tmr[c]  = reloadOf(func[c][FN_PER_LSB +: 4]);
                        if (code[c] == target[c]) next_mode[c] = CH_STATIC;
                    end
                end
                CH_WAVE: begin
                    if (tmr[c] == 32'h0) begin
                        // Zero period means an update every clock
                        next_tmr[c] = reloadOf(func[c][FN_PER_LSB +: 4]);
                        case (func[c][FN_WAVE_LSB +: 3])
                            WAVE_TRI: begin
                                // Same clipped stepping in both directions
                                if (dirUp[c]) begin
                                    next_code[c] = stepTo(code[c], mHigh[c], func[c][2:0]);
                                    if (next_code[c] == mHigh[c]) next_dirUp[c] = 1'b0;
                                end else begin
                                    next_code[c] = stepTo(code[c], mLow[c], func[c][2:0]);
                                    if (next_code[c] == mLow[c]) next_dirUp[c] = 1'b1;
                                end
                            end
                            WAVE_SAWUP: next_code[c] = (code[c] == mHigh[c]) ? mLow[c] :
                                stepTo(code[c], mHigh[c], func[c][2:0]);
                            WAVE_SAWDN: next_code[c] = (code[c] == mLow[c]) ? mHigh[c] :
                                stepTo(code[c], mLow[c], func[c][2:0]);
                            WAVE_SINE: begin
                                next_code[c]    = SINE_TAB[sineIdx[c]][11 -: CW];
                                next_sineIdx[c] = (sineIdx[c] == 5'(SINE_PTS - 1)) ?
                                                  5'h0 : sineIdx[c] + 5'h1;
                            end
                            default: next_code[c] = code[c];           // Reserved: hold
                        endcase
                    end
                end
                default: next_mode[c] = next_mode[c];                  // Static: hold
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl    <= CTRL_RST;
            ssState <= SS_IDLE;
            ssFlag  <= 1'b0;
            pinPrev <= 1'b0;
            prdata  <= 32'h0;
            hiZ     <= '1;
            for (int c = 0; c < NCH; c++) begin
                dataReg[c] <= '0;
                mHigh[c]   <= '0;
                mLow[c]    <= '0;
                func[c]    <= FUNC_RST;
                code[c]    <= '0;
                target[c]  <= '0;
                tmr[c]     <= 32'h0;
                dirUp[c]   <= 1'b1;
                sineIdx[c] <= 5'h0;
                mode[c]    <= CH_STATIC;
            end
        end else begin
            ctrl    <= next_ctrl;
            ssState <= next_ssState;
            ssFlag  <= next_ssFlag;
            pinPrev <= next_pinPrev;
            prdata  <= next_prdata;
            hiZ     <= next_hiZ;
            for (int c = 0; c < NCH; c++) begin
                dataReg[c] <= next_dataReg[c];
                mHigh[c]   <= next_mHigh[c];
                mLow[c]    <= next_mLow[c];
                func[c]    <= next_func[c];
                code[c]    <= next_code[c];
                target[c]  <= next_target[c];
                tmr[c]     <= next_tmr[c];
                dirUp[c]   <= next_dirUp[c];
                sineIdx[c] <= next_sineIdx[c];
                mode[c]    <= next_mode[c];
            end
        end
    end

    // Converter outputs straight from flops
    always_comb begin
        for (int c = 0; c < NCH; c++) dacCode[c*CW +: CW] = code[c];
        outHiZ = hiZ;
    end

endmodule : ossw_wavegen

`default_nettype wire

// [rtl/ossw_pkg.sv]
// Constants, register map and types for the output slew / safe-state / waveform sequencer
package ossw_pkg;

    // Default geometry
    localparam int NCH_DEF = 3;                 // Number of output channels
    localparam int CW_DEF  = 10;                // Converter code width
    // Clock period in 10 ps units, step periods in 10 ns units, so fractions of a us stay exact
    localparam int unsigned CLK_PERIOD_10PS = 400;
    typedef int unsigned ossw_cyc_t [15];
    localparam ossw_cyc_t STEP_TIME_10NS = '{
        400, 800, 1200, 1800, 2700, 4050, 6075, 9113,
        13669, 23920, 41861, 73256, 128198, 256396, 512792};

    // Cycles per step period; a period is a nominal figure, so it rounds down (never below 1)
    function automatic ossw_cyc_t ossw_cyc_calc();
        ossw_cyc_t r;
        for (int i = 0; i < 15; i++) begin
            r[i] = (STEP_TIME_10NS[i] * 1000 / CLK_PERIOD_10PS < 1) ? 1 :
                   STEP_TIME_10NS[i] * 1000 / CLK_PERIOD_10PS;
        end
        return r;
    endfunction : ossw_cyc_calc
    localparam ossw_cyc_t STEP_CYC_DEF = ossw_cyc_calc();

    // Step sizes in LSB per update, indexed by the 3-bit step field
    typedef logic [5:0] ossw_step_t [8];
    localparam ossw_step_t STEP_LSB = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};

    // Fixed sine points, 12-bit, 24 per cycle
    localparam int SINE_PTS = 24;
    typedef logic [11:0] ossw_sine_t [24];
    localparam ossw_sine_t SINE_TAB = '{
        12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f, 12'he66, 12'he2f,
        12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd, 12'h379,
        12'h275, 12'h1d1, 12'h19a, 12'h1d1, 12'h275, 12'h379, 12'h4cd, 12'h658};

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;  // Safe-state select and pin enable
    localparam logic [7:0] REG_TRIG   = 8'h04;  // Self-clearing commands
    localparam logic [7:0] REG_STATUS = 8'h08;  // comparator_status_reg
    localparam logic [7:0] CH_BASE    = 8'h10;  // First channel block
    localparam logic [7:0] CH_STRIDE  = 8'h10;  // Bytes per channel block
    localparam logic [3:0] CH_DATA    = 4'h0;   // Data code
    localparam logic [3:0] CH_MHIGH   = 4'h4;   // Margin-high code
    localparam logic [3:0] CH_MLOW    = 4'h8;   // Margin-low code
    localparam logic [3:0] CH_FUNC    = 4'hc;   // channel_function_reg

    // Field positions
    localparam int CTRL_SEL_LSB  = 0;           // [1:0] safe-state select
    localparam int CTRL_PIN_EN   = 2;           // multifunction_pin acts as safe input
    localparam int TRIG_SAFE     = 0;           // Start safe state
    localparam int TRIG_MHIGH    = 8;           // +ch: slew to margin-high
    localparam int TRIG_MLOW     = 12;          // +ch: slew to margin-low
    localparam int TRIG_PWRUP    = 16;          // +ch: power up at stored code
    localparam int TRIG_PWRDN    = 20;          // +ch: power down to Hi-Z
    localparam int ST_FLAG       = 0;           // Safe-state flag
    localparam int ST_BUSY       = 1;           // Safe-state sequence running
    localparam int ST_SLEW       = 4;           // +ch: channel slewing
    localparam int ST_HIZ        = 8;           // +ch: channel in Hi-Z
    localparam int FN_STEP_LSB   = 0;           // [2:0] step size
    localparam int FN_PER_LSB    = 3;           // [6:3] step period
    localparam int FN_WAVE_LSB   = 8;           // [10:8] waveform_select
    localparam int FN_RUN        = 11;          // Waveform running
    localparam int FN_W          = 12;          // Width of channel_function_reg

    // Reset values
    localparam logic [FN_W-1:0] FUNC_RST = 12'h000;
    localparam logic [2:0]      CTRL_RST = 3'h0;

    // Waveform encodings
    localparam logic [2:0] WAVE_TRI    = 3'b000;
    localparam logic [2:0] WAVE_SAWUP  = 3'b001;
    localparam logic [2:0] WAVE_SAWDN  = 3'b010;
    localparam logic [2:0] WAVE_SINE   = 3'b100;

    // Safe-state select encodings
    localparam logic [1:0] SS_HIZ_ONLY = 2'b00;
    localparam logic [1:0] SS_STORED   = 2'b01;
    localparam logic [1:0] SS_TO_LOW   = 2'b10;

    // Channel activity and safe-state sequencer states
    typedef enum logic [2:0] {CH_STATIC = 3'b001, CH_SLEW = 3'b010, CH_WAVE = 3'b100} ossw_ch_t;
    typedef enum logic [3:0] {SS_IDLE = 4'b0001, SS_JUMP = 4'b0010,
                              SS_SLEWING = 4'b0100, SS_HIZ = 4'b1000} ossw_ss_t;

endpackage : ossw_pkg

// [tb/ossw_wavegen_monitor.sv]
// Assertion checker bound to the sequencer top
`timescale 1ns/1ns
`default_nettype none
module ossw_wavegen_monitor import ossw_pkg::*; #(parameter int NCH = 3, parameter int CW = 10) (
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic [7:0]        paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              multifunction_pin,
    input wire logic [NCH*CW-1:0] dacCode,
    input wire logic [NCH-1:0]    outHiZ
);
    logic [2:0] sel;                               // Safe select and pin enable shadow
    logic [3:0] per;                               // Channel 0 step period shadow
    wire logic  wr = psel && penable && pwrite;    // Write taken at this edge
    always_ff @(posedge sys_clk) begin
        if (wr && paddr == REG_CTRL) sel <= pwdata[2:0];
        if (rst) {sel, per} <= {CTRL_RST, 4'h0};
        else if (wr && paddr == CH_BASE + 8'hc) per <= pwdata[6:3];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Safe start by register bit, or by the pin edge once the pin is enabled
    sequence sTrig;
        (wr && paddr == REG_TRIG && pwdata[TRIG_SAFE]) || ($rose(multifunction_pin) && sel[2]);
    endsequence
    chk_boot_hiz: assert property ($past(rst) |-> &outHiZ)
        else $error("Outputs not Hi-Z after reset");
    chk_power_up: assert property (wr && paddr == REG_TRIG && pwdata[TRIG_PWRUP]
        |-> ##[1:2] !outHiZ[0]) else $error("Channel 0 stayed Hi-Z");
    chk_safe_direct: assert property ((sTrig ##0 !sel[1]) |-> ##[1:4] &outHiZ)
        else $error("Direct safe state too slow");
    chk_safe_slew: assert property ((sTrig ##0 sel[1]) |-> ##[1:1000] &outHiZ)
        else $error("Slewed safe state never ended");
    chk_data_direct: assert property (wr && paddr == CH_BASE && per == 4'h0
        |=> dacCode[CW-1:0] == $past(pwdata[CW-1:0])) else $error("Data write not direct");
    chk_step_gap: assert property (per != 4'h0 && !$past(wr) && $changed(dacCode[CW-1:0])
        |=> $stable(dacCode[CW-1:0]) [*3]) else $error("Step came early");
    chk_unmapped_err: assert property (psel && penable && paddr >= 8'h50 |-> pslverr)
        else $error("Unmapped access without error");
    chk_mapped_ok: assert property (psel && penable && paddr <= REG_STATUS |-> pready && !pslverr)
        else $error("Mapped access refused");
endmodule : ossw_wavegen_monitor
bind ossw_wavegen ossw_wavegen_monitor #(.NCH(NCH), .CW(CW)) ossw_wavegen_monitor_inst (.*);
`default_nettype wire

// [tb/ossw_host_model.sv]
// Host controller model speaking APB to the sequencer
`timescale 1ns/1ns
`default_nettype none
module ossw_host_model (
    input  wire logic        sys_clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    logic [31:0] rdata;  // Last read word
    logic        rerr;   // Last error answer
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Setup, access held until pready, then release plus one idle edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk) penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {rdata, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge sys_clk);
    endtask : xfer
endmodule : ossw_host_model
`default_nettype wire

// [tb/ossw_wavegen_tb.sv]
// Self-checking bench for the sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ossw_wavegen_tb;
    import ossw_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, multifunction_pin = 1'b0, psel, penable, pwrite;
    logic pready, pslverr, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [29:0] dacCode;
    logic [2:0] outHiZ;
    logic [9:0] lo, hi, p, mn, mx;
    int err_total = 0, checks = 0, n, s;
    logic [2:0] wv [4] = '{WAVE_TRI, WAVE_SAWUP, WAVE_SAWDN, WAVE_SINE};
    always #2 sys_clk = ~sys_clk;
    ossw_wavegen #(.NVM_CODE(10'h155), .STEP_CYC('{default: 4})) ossw_wavegen_inst (.*);
    ossw_host_model ossw_host_model_inst (.*);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ossw_host_model_inst.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ossw_host_model_inst.xfer(1'b0, a, 32'h0);
        q = ossw_host_model_inst.rdata;
    endtask : rd
    // Next code of an upward slew, clipped at the target
    function automatic logic [9:0] nxt(input logic [9:0] c, t, input int k);
        return (t - c > 10'(STEP_LSB[k])) ? c + 10'(STEP_LSB[k]) : t;
    endfunction : nxt
    task automatic print_verdict();
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        #120000 err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h5900510d));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(REG_STATUS); `CHK("boot", 12'h700, q[11:0])
        rd(8'hf0); `CHK("unmapped", 1'b1, ossw_host_model_inst.rerr)
        wr(REG_TRIG, 32'h7 << TRIG_PWRUP); `CHK("pwrup", 13'h155, {outHiZ, dacCode[9:0]})
        repeat (4) begin
            p = 10'($urandom); wr(CH_BASE, 32'(p)); `CHK("data", p, dacCode[9:0])
        end
        // Margin-high slew for every step size, period code 1
        for (s = 0; s < 8; s++) begin
            hi = 10'($urandom_range(255, 1)); wr(CH_BASE, 32'h0); wr(CH_BASE + 8'h4, 32'(hi));
            wr(CH_BASE + 8'hc, 32'(s | 8)); wr(REG_TRIG, 32'h1 << TRIG_MHIGH);
            p = dacCode[9:0]; n = 0;
            while (p !== hi && n < 5000) begin
                @(posedge sys_clk); n++;
                if (dacCode[9:0] !== p) begin `CHK("step", nxt(p, hi, s), dacCode[9:0]) p = dacCode[9:0]; end
            end
            mn = 10'((hi + STEP_LSB[s] - 1) / STEP_LSB[s]);
            `CHK("time", 1'b1, n + 5 > 4 * mn && n <= 4 * mn)
            repeat (8) @(posedge sys_clk); rd(REG_STATUS); `CHK("hold", {1'b0, hi}, {q[ST_SLEW], dacCode[9:0]})
        end
        foreach (wv[i]) begin
            lo = 10'($urandom_range(100)); hi = lo + 10'($urandom_range(200, 20)); mn = hi; mx = lo;
            wr(CH_BASE + 8'h8, 32'(lo)); wr(CH_BASE + 8'h4, 32'(hi));
            wr(CH_BASE + 8'hc, {21'h1, wv[i], 8'h0a}); repeat (4) @(posedge sys_clk); // First update
            repeat (800) begin
                @(posedge sys_clk); ok = 1'b0; foreach (SINE_TAB[j]) ok |= SINE_TAB[j][11:2] == dacCode[9:0];
                if (wv[i] == WAVE_SINE) `CHK("sine", 1'b1, ok)
                mn = dacCode[9:0] < mn ? dacCode[9:0] : mn; mx = dacCode[9:0] > mx ? dacCode[9:0] : mx;
            end
            if (wv[i] != WAVE_SINE) `CHK("bounds", {lo, hi}, {mn, mx})
            wr(CH_BASE + 8'hc, 32'h0); `CHK("indep", 10'h155, dacCode[19:10])
        end
        // Every safe select; the last one is started from the pin
        for (s = 0; s < 4; s++) begin
            lo = 10'($urandom_range(250, 200)); hi = lo + 10'd50; wr(REG_TRIG, 32'h7 << TRIG_PWRUP);
            wr(CH_BASE, 32'(lo + 10'd25)); wr(CH_BASE + 8'hc, 32'h8); wr(CH_BASE + 8'h8, 32'(lo));
            wr(CH_BASE + 8'h4, 32'(hi)); wr(REG_CTRL, 32'(s | 4));
            if (s == 3) begin multifunction_pin <= 1'b1; @(posedge sys_clk); multifunction_pin <= 1'b0; end
            else wr(REG_TRIG, 32'h1);
            rd(REG_STATUS); `CHK("flag", 1'b1, q[ST_FLAG])
            wr(CH_BASE + 8'h10, 32'h3); n = 0;
            while (outHiZ !== 3'b111 && n < 2000) begin @(posedge sys_clk); n++; end
            `CHK("safe", {3'b111, s == 1 ? 10'h155 : s == 2 ? lo : s == 3 ? hi : lo + 10'd25}, {outHiZ, dacCode[9:0]})
            if (s > 1) `CHK("locked", 10'h0, dacCode[19:10])
            rd(REG_STATUS); if (s > 1) `CHK("kept", 1'b1, q[ST_FLAG])
            rd(REG_STATUS); `CHK("cleared", 2'b00, q[1:0])
            wr(CH_BASE + 8'h10, 32'h5); `CHK("reopen", 10'h5, dacCode[19:10])
        end
        print_verdict();
    end
endmodule : ossw_wavegen_tb
`default_nettype wire
